// ---- logic/apcb_pkg.sv ----
package apcb_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [15:0] OFS_MCLK_CTRL   = 16'h1009;
  localparam logic [15:0] OFS_PDN_TWO     = 16'h1102;
  localparam logic [15:0] OFS_OSC_CTRL    = 16'h1107;
  localparam logic [15:0] OFS_OSC_STAT    = 16'h1109;
  localparam logic [15:0] OFS_MCLK_SRC    = 16'h1201;
  localparam logic [15:0] OFS_PULSE_LOW   = 16'h1203;
  localparam logic [15:0] OFS_PULSE_HIGH  = 16'h1204;
  localparam logic [15:0] OFS_PERIOD_LOW  = 16'h1205;
  localparam logic [15:0] OFS_PERIOD_HIGH = 16'h1206;
  localparam logic [15:0] OFS_PORT_CLK    = 16'h1207;
  localparam logic [15:0] OFS_RX_STAT     = 16'h1210;
  localparam logic [15:0] OFS_RX_SLOT     = 16'h2501;
  localparam logic [15:0] OFS_RX_ISOC     = 16'h2502;

  // Values after reset
  localparam logic [7:0] RST_MCLK_CTRL = 8'h00;
  localparam logic [7:0] RST_PDN_TWO   = 8'h9C;
  localparam logic [7:0] RST_OSC_CTRL  = 8'h00;
  localparam logic [7:0] RST_MCLK_SRC  = 8'h00;
  localparam logic [7:0] RST_PULSE     = 8'h01;
  localparam logic [7:0] RST_PERIOD_LO = 8'hFF;
  localparam logic [7:0] RST_PERIOD_HI = 8'h00;
  localparam logic [7:0] RST_PORT_CLK  = 8'h00;
  localparam logic [7:0] RST_RX_SLOT   = 8'h04;
  localparam logic [7:0] RST_RX_ISOC   = 8'h00;

  // Field positions
  localparam int unsigned BIT_RATE_SEL     = 1;
  localparam int unsigned BIT_REFERENCE_FILTER_NODE_CLAMP   = 4;
  localparam int unsigned BIT_CONV_OVR     = 3;
  localparam int unsigned BIT_PORT_PDN     = 2;
  localparam int unsigned BIT_PLAY_PWR_N   = 1;
  localparam int unsigned BIT_CAPT_PWR_N   = 0;
  localparam int unsigned BIT_CLK_PRESENT  = 0;
  localparam int unsigned BIT_STAT_RC_ON   = 1;
  localparam int unsigned BIT_STAT_EXT_SEL = 0;
  localparam int unsigned BIT_MCLK_SRC     = 0;
  localparam int unsigned BIT_BCLK_EN      = 5;
  localparam int unsigned BIT_HYBRID       = 4;
  localparam int unsigned BIT_SCPOL_ADC    = 3;
  localparam int unsigned BIT_SCPOL_DAC    = 2;
  localparam int unsigned BIT_LCPOL_OUT    = 1;
  localparam int unsigned BIT_LCPOL_IN     = 0;
  localparam int unsigned BIT_RX_RSYNC     = 4;

  // Cycle counts, slot shift and sample width
  localparam int unsigned RATE_DIV      = 256;
  localparam logic [3:0]  RC_OFF_CYCLES = 4'hF;
  localparam int unsigned SLOT_SHIFT    = 6;
  localparam int unsigned SAMPLE_W      = 24;

  // Oscillator switch states
  typedef enum logic [1:0] {
    OSC_RC   = 2'b00,
    OSC_WAIT = 2'b01,
    OSC_EXT  = 2'b10,
    OSC_OFF  = 2'b11
  } apcb_osc_t;

endpackage : apcb_pkg

// ---- logic/apcb_fifo_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface apcb_fifo_if #(parameter int unsigned W = 25);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport src (output in_valid, input in_ready, output in_data,
               input out_valid, output out_ready, input out_data);
  modport buf_side (input in_valid, output in_ready, input in_data,
                    output out_valid, input out_ready, output out_data);
endinterface : apcb_fifo_if
`default_nettype wire

// ---- logic/apcb_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module apcb_fifo #(
  parameter int unsigned W = 25,
  parameter int unsigned D = 8
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  apcb_fifo_if.buf_side f
);
  localparam int unsigned PW = $clog2(D);
  localparam int unsigned CW = $clog2(D + 1);

  logic [W-1:0]  mem_reg [D];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] cnt_reg;
  logic          push;
  logic          pop;

  // Honest full: ready only while the store has room
  assign f.in_ready = (cnt_reg != CW'(D));
  assign push       = f.in_valid && f.in_ready;
  assign pop        = (cnt_reg != '0) && (!f.out_valid || f.out_ready);

  // Storage write
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wptr_reg] <= f.in_data;
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= (wptr_reg == PW'(D - 1)) ? '0 : wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= (rptr_reg == PW'(D - 1)) ? '0 : rptr_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Registered read stage
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      f.out_valid <= 1'b0;
      f.out_data  <= '0;
    end
    else if (pop)
    begin
      f.out_valid <= 1'b1;
      f.out_data  <= mem_reg[rptr_reg];
    end
    else if (f.out_ready)
      f.out_valid <= 1'b0;
  end
endmodule : apcb_fifo
`default_nettype wire

// ---- logic/apcb_port.sv ----
// Overview of operation
// - Converters up when override, port-down clear
// - Discharge bit clamps reference filter node
// - Clock-present write moves core to bit clock
// - Status shows oscillator power and clock source
// - Rate select gives master clock over 256
// - Source zero: bit clock pin, divide one
// - Frame period in bit clocks, two bytes
// - Frame high time from pulse-width bytes
// - Zero config: clock off, normal, frame input
// - Sync zero default, isochronous 00 native
// - Two-bit slot positions for channels B, A
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module apcb_port #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        bit_clk,
  input  wire logic        frame_clk_in,
  output logic             frame_clk_out,
  output logic             frame_clk_oe,
  input  wire logic        serial_data,
  output logic             core_clk_ext,
  output logic             rc_osc_on,
  output logic             playback_on,
  output logic             capture_on,
  output logic             filter_clamp,
  output logic             rate_tick,
  output logic             port_clk_on,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [24:0] rx_data
);
  localparam int unsigned WORD_W = apcb_pkg::SAMPLE_W + 1;

  // Register storage
  logic [7:0] mclk_ctrl_reg, pdn_two_reg, osc_ctrl_reg, mclk_src_reg;
  logic [7:0] pulse_lo_reg, pulse_hi_reg, period_lo_reg, period_hi_reg;
  logic [7:0] port_clk_reg, rx_slot_reg, rx_isoc_reg;
  logic       overflow_reg;
  logic [3:0] hit;

  // Receive and timing state
  apcb_pkg::apcb_osc_t osc_state_reg;
  logic [3:0]  settle_reg;
  logic        bclk_d_reg, frame_d_reg, frame_pend_reg;
  logic [15:0] pos_reg;
  logic [1:0]  mdiv_reg;
  logic [7:0]  rate_cnt_reg;
  logic [apcb_pkg::SAMPLE_W-1:0] shift_reg;
  logic        push_reg;
  logic [WORD_W-1:0] push_word_reg;

  // Decoded controls
  logic        port_up, rx_run, bit_tick, frame_edge, frame_start, mclk_tick;
  logic        bclk_pol, frame_lvl, hybrid, drop;
  logic [15:0] period, width, spos;
  logic [1:0]  slot;
  logic [5:0]  bit_in_slot;

  apcb_fifo_if #(.W(WORD_W)) rxf ();

  // Address decode shared by write and read
  function automatic logic [3:0] reg_index(input logic [15:0] a);
    unique case (a)
      apcb_pkg::OFS_MCLK_CTRL:   reg_index = 4'h1;
      apcb_pkg::OFS_PDN_TWO:     reg_index = 4'h2;
      apcb_pkg::OFS_OSC_CTRL:    reg_index = 4'h3;
      apcb_pkg::OFS_OSC_STAT:    reg_index = 4'h4;
      apcb_pkg::OFS_MCLK_SRC:    reg_index = 4'h5;
      apcb_pkg::OFS_PULSE_LOW:   reg_index = 4'h6;
      apcb_pkg::OFS_PULSE_HIGH:  reg_index = 4'h7;
      apcb_pkg::OFS_PERIOD_LOW:  reg_index = 4'h8;
      apcb_pkg::OFS_PERIOD_HIGH: reg_index = 4'h9;
      apcb_pkg::OFS_PORT_CLK:    reg_index = 4'hA;
      apcb_pkg::OFS_RX_STAT:     reg_index = 4'hB;
      apcb_pkg::OFS_RX_SLOT:     reg_index = 4'hC;
      apcb_pkg::OFS_RX_ISOC:     reg_index = 4'hD;
      default:                   reg_index = 4'h0;
    endcase
  endfunction : reg_index

  assign hit = reg_index(reg_addr);

  // Control field decode
  assign port_up  = !pdn_two_reg[apcb_pkg::BIT_CONV_OVR]
                    && !pdn_two_reg[apcb_pkg::BIT_PORT_PDN];
  assign hybrid   = port_clk_reg[apcb_pkg::BIT_HYBRID];
  assign bclk_pol = bit_clk ^ port_clk_reg[apcb_pkg::BIT_SCPOL_DAC];
  assign bit_tick = bclk_pol && !bclk_d_reg;
  assign frame_lvl  = frame_clk_in ^ port_clk_reg[apcb_pkg::BIT_LCPOL_IN];
  assign frame_edge = frame_lvl && !frame_d_reg;
  assign period = {period_hi_reg, period_lo_reg};
  assign width  = {pulse_hi_reg, pulse_lo_reg};
  assign frame_start = bit_tick && (hybrid ? (pos_reg >= period) : frame_pend_reg);
  assign rx_run = port_up && port_clk_reg[apcb_pkg::BIT_BCLK_EN] && core_clk_ext
                  && (rx_isoc_reg[1:0] == 2'b00);
  assign spos = pos_reg - {15'h0000, rx_isoc_reg[apcb_pkg::BIT_RX_RSYNC]};
  assign slot        = spos[apcb_pkg::SLOT_SHIFT+1:apcb_pkg::SLOT_SHIFT];
  assign bit_in_slot = spos[apcb_pkg::SLOT_SHIFT-1:0];
  assign mclk_tick = bit_tick && !mclk_src_reg[apcb_pkg::BIT_MCLK_SRC]
                     && (mdiv_reg == mclk_src_reg[2:1]);
  assign drop = push_reg && !rxf.in_ready;

  // Software writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mclk_ctrl_reg <= apcb_pkg::RST_MCLK_CTRL;
      pdn_two_reg   <= apcb_pkg::RST_PDN_TWO;
      osc_ctrl_reg  <= apcb_pkg::RST_OSC_CTRL;
      mclk_src_reg  <= apcb_pkg::RST_MCLK_SRC;
      pulse_lo_reg  <= apcb_pkg::RST_PULSE;
      pulse_hi_reg  <= 8'h00;
      period_lo_reg <= apcb_pkg::RST_PERIOD_LO;
      period_hi_reg <= apcb_pkg::RST_PERIOD_HI;
      port_clk_reg  <= apcb_pkg::RST_PORT_CLK;
      rx_slot_reg   <= apcb_pkg::RST_RX_SLOT;
      rx_isoc_reg   <= apcb_pkg::RST_RX_ISOC;
    end
    else if (reg_wr)
    begin
      unique case (hit)
        4'h1: mclk_ctrl_reg <= reg_wdata;
        4'h2: pdn_two_reg   <= reg_wdata;
        4'h3: osc_ctrl_reg  <= reg_wdata;
        4'h5: mclk_src_reg  <= reg_wdata;
        4'h6: pulse_lo_reg  <= reg_wdata;
        4'h7: pulse_hi_reg  <= reg_wdata;
        4'h8: period_lo_reg <= reg_wdata;
        4'h9: period_hi_reg <= reg_wdata;
        4'hA: port_clk_reg  <= reg_wdata;
        4'hC: rx_slot_reg   <= reg_wdata;
        4'hD: rx_isoc_reg   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (hit)
        4'h1: reg_rdata <= mclk_ctrl_reg;
        4'h2: reg_rdata <= pdn_two_reg;
        4'h3: reg_rdata <= osc_ctrl_reg;
        4'h4: reg_rdata <= {6'h00, rc_osc_on, core_clk_ext};
        4'h5: reg_rdata <= mclk_src_reg;
        4'h6: reg_rdata <= pulse_lo_reg;
        4'h7: reg_rdata <= pulse_hi_reg;
        4'h8: reg_rdata <= period_lo_reg;
        4'h9: reg_rdata <= period_hi_reg;
        4'hA: reg_rdata <= port_clk_reg;
        4'hB: reg_rdata <= {6'h00, !rxf.in_ready, overflow_reg};
        4'hC: reg_rdata <= rx_slot_reg;
        4'hD: reg_rdata <= rx_isoc_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Sticky overflow, cleared by read; a new drop wins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      overflow_reg <= 1'b0;
    else if (drop)
      overflow_reg <= 1'b1;
    else if (reg_rd && hit == 4'hB)
      overflow_reg <= 1'b0;
  end

  // Power, clamp and port-clock outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      playback_on  <= 1'b0;
      capture_on   <= 1'b0;
      filter_clamp <= 1'b0;
      port_clk_on  <= 1'b0;
    end
    else
    begin
      playback_on  <= port_up && pdn_two_reg[apcb_pkg::BIT_PLAY_PWR_N];
      capture_on   <= port_up && pdn_two_reg[apcb_pkg::BIT_CAPT_PWR_N];
      filter_clamp <= pdn_two_reg[apcb_pkg::BIT_REFERENCE_FILTER_NODE_CLAMP];
      port_clk_on  <= port_clk_reg[apcb_pkg::BIT_BCLK_EN];
    end
  end

  // Core clock move from internal oscillator to bit clock
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_state_reg <= apcb_pkg::OSC_RC;
      settle_reg    <= 4'h0;
      core_clk_ext  <= 1'b0;
      rc_osc_on     <= 1'b1;
    end
    else if (!osc_ctrl_reg[apcb_pkg::BIT_CLK_PRESENT])
    begin
      osc_state_reg <= apcb_pkg::OSC_RC;
      core_clk_ext  <= 1'b0;
      rc_osc_on     <= 1'b1;
    end
    else
    begin
      unique case (osc_state_reg)
        apcb_pkg::OSC_RC: osc_state_reg <= apcb_pkg::OSC_WAIT;
        apcb_pkg::OSC_WAIT:
          if (bit_tick)
          begin
            osc_state_reg <= apcb_pkg::OSC_EXT;
            core_clk_ext  <= 1'b1;
            settle_reg    <= 4'h0;
          end
        apcb_pkg::OSC_EXT:
          if (settle_reg == apcb_pkg::RC_OFF_CYCLES)
          begin
            osc_state_reg <= apcb_pkg::OSC_OFF;
            rc_osc_on     <= 1'b0;
          end
          else
            settle_reg <= settle_reg + 1'b1;
        apcb_pkg::OSC_OFF: osc_state_reg <= apcb_pkg::OSC_OFF;
      endcase
    end
  end

  // Master clock divider and internal sample-rate tick
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdiv_reg     <= 2'b00;
      rate_cnt_reg <= 8'h00;
      rate_tick    <= 1'b0;
    end
    else
    begin
      if (bit_tick)
        mdiv_reg <= (mdiv_reg == mclk_src_reg[2:1]) ? 2'b00 : mdiv_reg + 1'b1;
      rate_tick <= 1'b0;
      if (!mclk_ctrl_reg[apcb_pkg::BIT_RATE_SEL])
        rate_cnt_reg <= 8'h00;
      else if (mclk_tick)
      begin
        rate_cnt_reg <= rate_cnt_reg + 1'b1;
        rate_tick    <= (rate_cnt_reg == 8'(apcb_pkg::RATE_DIV - 1));
      end
    end
  end

  // Bit position within the frame
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bclk_d_reg     <= 1'b0;
      frame_d_reg    <= 1'b0;
      frame_pend_reg <= 1'b0;
      pos_reg        <= 16'h0000;
    end
    else
    begin
      bclk_d_reg  <= bclk_pol;
      frame_d_reg <= frame_lvl;
      if (frame_edge)
        frame_pend_reg <= 1'b1;
      else if (bit_tick)
        frame_pend_reg <= 1'b0;
      if (frame_start)
        pos_reg <= 16'h0000;
      else if (bit_tick && pos_reg != 16'hFFFF)
        pos_reg <= pos_reg + 1'b1;
    end
  end

  // Frame clock drive in hybrid mode, input otherwise
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_clk_out <= 1'b0;
      frame_clk_oe  <= 1'b0;
    end
    else
    begin
      frame_clk_oe  <= hybrid;
      frame_clk_out <= ((pos_reg < width) || (pos_reg == 16'h0000))
                       ^ port_clk_reg[apcb_pkg::BIT_LCPOL_OUT];
    end
  end

  // Slot capture for channels A and B
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_reg     <= '0;
      push_reg      <= 1'b0;
      push_word_reg <= '0;
    end
    else
    begin
      push_reg <= 1'b0;
      if (bit_tick && rx_run && bit_in_slot < 6'(apcb_pkg::SAMPLE_W)
          && (slot == rx_slot_reg[1:0] || slot == rx_slot_reg[3:2]))
      begin
        shift_reg <= {shift_reg[apcb_pkg::SAMPLE_W-2:0], serial_data};
        if (bit_in_slot == 6'(apcb_pkg::SAMPLE_W - 1))
        begin
          push_reg      <= 1'b1;
          push_word_reg <= {slot != rx_slot_reg[1:0],
                            shift_reg[apcb_pkg::SAMPLE_W-2:0], serial_data};
        end
      end
    end
  end

  // Sample buffer toward the user side
  assign rxf.in_valid  = push_reg;
  assign rxf.in_data   = push_word_reg;
  assign rxf.out_ready = rx_ready;
  assign rx_valid      = rxf.out_valid;
  assign rx_data       = rxf.out_data;

  apcb_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .f       (rxf)
  );

  // Checks
  a_conv_power_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pdn_two_reg[4:0] == 5'h03) |=> (playback_on && capture_on))
    else $error("converters not powered up");
  a_filter_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> (filter_clamp == $past(pdn_two_reg[apcb_pkg::BIT_REFERENCE_FILTER_NODE_CLAMP])))
    else $error("clamp does not follow discharge bit");
  a_clk_switch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (osc_state_reg == apcb_pkg::OSC_WAIT && osc_ctrl_reg[0] && bit_tick) |=> core_clk_ext)
    else $error("core clock did not move to bit clock");
  a_osc_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && hit == 4'h4) |=> (reg_rdata == {6'h00, $past(rc_osc_on), $past(core_clk_ext)}))
    else $error("oscillator status read wrong");
  a_rate_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rate_tick |-> (mclk_ctrl_reg[apcb_pkg::BIT_RATE_SEL] && $past(rate_cnt_reg) == 8'hFF))
    else $error("rate tick not at 256 master clocks");
  a_mclk_div_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bit_tick && mclk_src_reg[2:0] == 3'b000) |-> mclk_tick)
    else $error("bit clock not used as master clock");
  a_frame_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hybrid && bit_tick && pos_reg == period) |=> (pos_reg == 16'h0000))
    else $error("frame period not honoured");
  a_frame_input: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port_clk_reg == 8'h00) |=> (!frame_clk_oe && !port_clk_on))
    else $error("zero config drives frame clock or bit clock");
  a_rx_native: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx_isoc_reg[1:0] != 2'b00) |=> !push_reg)
    else $error("capture outside native mode");
endmodule : apcb_port
`default_nettype wire

// ---- dv/apcb_audio_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module apcb_audio_master #(
  parameter logic [23:0] W0 = 24'h000000,
  parameter logic [23:0] W1 = 24'h000000,
  parameter logic [23:0] W2 = 24'h000000,
  parameter logic [23:0] W3 = 24'h000000
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      bit_clk,
  output logic      frame_clk,
  output logic      serial_data
);
  logic [1:0]  ph_reg;
  logic [7:0]  pos_reg;
  logic [7:0]  np;
  logic [23:0] word;

  // Sample word of the slot that the next bit falls in
  assign np = pos_reg + 8'h01;
  assign word = (np[7:6] == 2'h0) ? W0 : (np[7:6] == 2'h1) ? W1 : (np[7:6] == 2'h2) ? W2 : W3;

  // Bit clock of four system cycles, 256 bits a frame, clocks still while not running
  // Frame clock marks the bit two ahead of slot 0, so the port counts bit 0 as position 0
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_reg      <= 2'h0;
      pos_reg     <= 8'hFF;
      bit_clk     <= 1'b0;
      frame_clk   <= 1'b0;
      serial_data <= 1'b0;
    end
    else if (run)
    begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h1)
      begin
        bit_clk   <= 1'b1;
        pos_reg   <= np;
        frame_clk <= (np == 8'hFE);
      end
      if (ph_reg == 2'h3)
      begin
        bit_clk     <= 1'b0;
        serial_data <= (np[5:0] < 6'd24) ? word[5'd23 - np[4:0]] : np[0];
      end
    end
    else
    begin
      bit_clk     <= 1'b0;
      frame_clk   <= 1'b0;
      serial_data <= ~serial_data; // Stale line keeps moving
    end
  end
endmodule : apcb_audio_master
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [23:0] W0 = 24'hA53C96;
  localparam logic [23:0] W1 = 24'h5AC369;
  logic        sys_clk, rst_n, reg_wr, reg_rd, run, rx_ready;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        bit_clk, frame_clk, serial_data, frame_clk_out, frame_clk_oe;
  logic        core_clk_ext, rc_osc_on, playback_on, capture_on, filter_clamp;
  logic        rate_tick, port_clk_on, rx_valid;
  logic [24:0] rx_data;
  int          n_errors, cmp_count, n;

  apcb_port apcb_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_clk(bit_clk), .frame_clk_in(frame_clk), .frame_clk_out(frame_clk_out),
    .frame_clk_oe(frame_clk_oe), .serial_data(serial_data), .core_clk_ext(core_clk_ext),
    .rc_osc_on(rc_osc_on), .playback_on(playback_on), .capture_on(capture_on),
    .filter_clamp(filter_clamp), .rate_tick(rate_tick), .port_clk_on(port_clk_on),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
  apcb_audio_master #(.W0(W0), .W1(W1), .W2(24'h0F0F0F), .W3(24'hF0F0F0))
    apcb_audio_master_i (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .bit_clk(bit_clk),
    .frame_clk(frame_clk), .serial_data(serial_data));

  // System clock, 20 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task close_out;
    $display("errors %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task check_val(input logic [24:0] seen, input logic [24:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check_val({17'h0, reg_rdata}, {17'h0, e});
  endtask : rd_chk

  // Settled look at outputs a few cycles after a write
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  function automatic logic pick(input int s);
    case (s)
      0: return core_clk_ext;
      1: return rc_osc_on;
      2: return rate_tick;
      3: return frame_clk_out;
      default: return frame_clk;
    endcase
  endfunction : pick

  // Bounded wait for a level, cnt counts the cycles spent
  task wait_for(input int s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(s) !== v && cnt < lim)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    if (pick(s) !== v)
    begin
      n_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out;
    end
  endtask : wait_for

  task t_reset;
    static logic [15:0] ofs [11] = '{16'h1009, 16'h1102, 16'h1107, 16'h1201, 16'h1203,
                                     16'h1204, 16'h1205, 16'h1206, 16'h1207, 16'h2501,
                                     16'h2502};
    static logic [7:0]  rv [11] = '{8'h00, 8'h9C, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h00,
                                    8'h00, 8'h04, 8'h00};
    for (int i = 0; i < 11; i++)
      rd_chk(ofs[i], rv[i]);
    rd_chk(16'h1300, 8'h00);
    wr_reg(16'h1109, 8'hFF);
    rd_chk(16'h1109, 8'h02);
  endtask : t_reset

  task t_power;
    wr_reg(16'h1102, 8'h9C);
    settle;
    check_val({22'h0, playback_on, capture_on, filter_clamp}, 25'h1);
    wr_reg(16'h1102, 8'h8B);
    settle;
    check_val({22'h0, playback_on, capture_on, filter_clamp}, 25'h0);
    wr_reg(16'h1102, 8'h83);
    settle;
    check_val({22'h0, playback_on, capture_on, filter_clamp}, 25'h6);
  endtask : t_power

  task t_osc;
    @(posedge sys_clk);
    run <= 1'b1;
    wr_reg(16'h1107, 8'h01);
    wait_for(0, 1'b1, 40, n);
    wait_for(1, 1'b0, 24, n);
    rd_chk(16'h1109, 8'h01);
  endtask : t_osc

  task t_rate;
    wr_reg(16'h1201, 8'h00);
    wr_reg(16'h1009, 8'h02);
    wait_for(2, 1'b1, 1100, n);
    @(posedge sys_clk);
    #1;
    wait_for(2, 1'b1, 1100, n);
    check_val(25'(n + 1), 25'd1024);
  endtask : t_rate

  task t_hybrid;
    int h;
    wr_reg(16'h2502, 8'h01);
    wr_reg(16'h1203, 8'h03);
    wr_reg(16'h1207, 8'h30);
    settle;
    check_val({23'h0, frame_clk_oe, port_clk_on}, 25'h3);
    wait_for(3, 1'b0, 1100, n);
    wait_for(3, 1'b1, 1100, n);
    wait_for(3, 1'b0, 1100, h);
    wait_for(3, 1'b1, 1100, n);
    check_val(25'(h), 25'd12);
    check_val(25'(h + n), 25'd1024);
    wr_reg(16'h1207, 8'h32);
    settle;
    wait_for(3, 1'b1, 1100, n);
    wait_for(3, 1'b0, 1100, n);
    wait_for(3, 1'b1, 1100, h);
    check_val(25'(h), 25'd12);
    wr_reg(16'h1207, 8'h00);
    settle;
    check_val({23'h0, frame_clk_oe, port_clk_on}, 25'h0);
    rd_chk(16'h1210, 8'h00);
  endtask : t_hybrid

  task t_rx;
    int got;
    got = 0;
    wr_reg(16'h2502, 8'h00);
    wr_reg(16'h2501, 8'h04);
    wait_for(4, 1'b0, 1100, n);
    wait_for(4, 1'b1, 1100, n);
    wr_reg(16'h1207, 8'h20);
    repeat (6200) @(posedge sys_clk);
    wr_reg(16'h1207, 8'h00);
    rd_chk(16'h1210, 8'h03);
    rd_chk(16'h1210, 8'h02);
    repeat (20) @(posedge sys_clk);
    rx_ready <= 1'b1;
    repeat (40)
    begin
      @(negedge sys_clk);
      if (rx_valid === 1'b1)
      begin
        check_val(rx_data, {got[0], got[0] ? W1 : W0});
        got++;
      end
    end
    check_val(25'(got), 25'd9);
    rd_chk(16'h1210, 8'h00);
  endtask : t_rx

  // Reset, then scenarios in bring-up order
  initial
  begin
    n_errors  = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 8'h00;
    run       = 1'b0;
    rx_ready  = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check_val({20'h0, rc_osc_on, core_clk_ext, playback_on, rx_valid, port_clk_on}, 25'h10);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge sys_clk);
    t_reset;
    t_power;
    t_osc;
    t_rate;
    t_hybrid;
    t_rx;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
